// *** verilog/ccu_capture_compare.v ***
// Behaviour
// - sixteen channels, one or eight cycle resolution
// - two 16-bit timers, each with reload
// - timer clock from prescaler or sixth timer
// - first timer also counts external input
// - each channel picks timer and function
// - ten channels own a capture/compare pin
// - mode 0 interrupts only, many per period
// - mode 1 toggles pin each match
// - mode 2 interrupts once per period
// - mode 3 sets pin, overflow clears it
// - double mode: two channels toggle one pin
// - single event option on any compare mode
// - capture copies allocated timer into channel
// - every capture raises channel interrupt
// - capture edge rising, falling or both
// - compare channels match allocated timer the cycle after it counts
`timescale 1ns/1ns
`include "ccu_map.vh"
module ccu_capture_compare #(
  parameter NCH  = 16,
  parameter NPIN = 10
) (
  input  wire            core_clk_in,
  input  wire            rst_in,
  input  wire [7:0]      addr_in,
  input  wire [15:0]     wdata_in,
  input  wire            wr_in,
  input  wire            rd_in,
  output reg  [15:0]     rdata_out,
  input  wire            gp_sixth_timer_ovf_in,
  input  wire            ext_count_in,
  input  wire [NPIN-1:0] cc_pin_in,
  output wire [NPIN-1:0] cc_pin_out,
  output wire [NPIN-1:0] cc_pin_oe_out,
  output wire            irq_out
);

  reg  [15:0]            tctrl_reg;
  reg  [15:0]            tval_reg [0:1];
  reg  [15:0]            trel_reg [0:1];
  reg  [`CCU_PRE_W-1:0]  pre_reg;
  reg                    ext_d_reg;
  reg  [NCH-1:0]         istat_reg;
  reg  [NCH-1:0]         imask_reg;
  reg  [7:0]             double_reg;
  reg  [6:0]             cfg_reg [0:NCH-1];
  reg  [15:0]            val_reg [0:NCH-1];
  reg  [NCH-1:0]         done_reg;
  reg  [NPIN-1:0]        pin_reg;
  reg  [NPIN-1:0]        pin_d_reg;
  reg  [1:0]             adv_d_reg;
  reg  [1:0]             ovf_d_reg;
  reg  [1:0]             tick;
  reg  [1:0]             ovf;
  reg  [NCH-1:0]         cmp_hit;
  reg  [NCH-1:0]         cap_hit;
  reg  [NCH-1:0]         ev_set;
  reg  [NPIN-1:0]        pin_next;
  reg  [NPIN-1:0]        pin_oe;
  reg  [15:0]            rd_mux;
  reg  [2:0]             sel;        // source of the timer being decoded
  reg  [2:0]             mode_e;     // channel mode seen by the event decode
  reg                    ts_e;       // allocated timer seen by the event decode
  reg  [2:0]             mode_p;     // channel mode seen by the pin logic
  reg                    ts_p;       // allocated timer seen by the pin logic
  reg                    rise;
  reg                    fall;
  wire                   ext_rise;
  wire                   stagger_ok;
  // one loop index per process keeps every variable single-driven
  integer                kt;
  integer                ke;
  integer                kp;
  integer                kr;
  integer                kc;

  assign ext_rise      = ext_count_in & ~ext_d_reg;
  // staggered operation slows the divide-by-one tick to one in eight cycles
  // stagger resolution
  assign stagger_ok    = ~tctrl_reg[`CCU_TC_STAGGER] | (pre_reg[2:0] == `CCU_STAGGER_DIV);
  // pin levels leave from flip-flops, the direction follows the config
  assign cc_pin_out    = pin_reg;
  assign cc_pin_oe_out = pin_oe;
  // level interrupt: any unmasked sticky bit keeps it high
  assign irq_out       = |(istat_reg & imask_reg);

  // count clock enables for both timers
  always @* begin
    tick = 2'b00;
    ovf  = 2'b00;
    sel  = 3'h0;
    for (kt = 0; kt < 2; kt = kt + 1) begin
      // each timer owns one byte of the control word
      sel = tctrl_reg[`CCU_TC_STRIDE*kt+`CCU_TC_SEL_HI -: 3];
      case (sel)
        `CCU_SEL_DIV1:   tick[kt] = stagger_ok;
        `CCU_SEL_DIV8:   tick[kt] = (pre_reg[2:0] == 3'h7);
        `CCU_SEL_DIV64:  tick[kt] = (pre_reg[5:0] == 6'h3F);
        `CCU_SEL_DIV512: tick[kt] = (pre_reg == 9'h1FF);
        `CCU_SEL_GPT6:   tick[kt] = gp_sixth_timer_ovf_in;
        // external count input
        // the second timer has no external input and stays still
        `CCU_SEL_EXT:    tick[kt] = (kt == 0) ? ext_rise : 1'b0;
        default:         tick[kt] = 1'b0;
      endcase
      // a stopped timer never ticks, so it cannot overflow either
      tick[kt] = tick[kt] & tctrl_reg[`CCU_TC_STRIDE*kt+`CCU_TC_RUN];
      // overflow is the tick that finds the timer at its top value
      ovf[kt]  = tick[kt] & (tval_reg[kt] == `CCU_TMAX);
    end
  end

  // per-channel events; compares evaluated the cycle after the timer moved;
  // waiting for the new count avoids matching on a stale value
  always @* begin
    cmp_hit = {NCH{1'b0}};
    cap_hit = {NCH{1'b0}};
    mode_e  = 3'h0;
    ts_e    = 1'b0;
    rise    = 1'b0;
    fall    = 1'b0;
    for (ke = 0; ke < NCH; ke = ke + 1) begin
      mode_e = cfg_reg[ke][`CCU_CF_MODE_HI:`CCU_CF_MODE_LO];
      ts_e   = cfg_reg[ke][`CCU_CF_TSEL];
      if (mode_e[2] && adv_d_reg[ts_e] && (tval_reg[ts_e] == val_reg[ke]) && !done_reg[ke]) begin
        cmp_hit[ke] = 1'b1;
      end
      // only the low channels own a pin to capture from
      if (ke < NPIN) begin
        rise = cc_pin_in[ke] & ~pin_d_reg[ke];
        fall = ~cc_pin_in[ke] & pin_d_reg[ke];
        if (mode_e == `CCU_M_CAPTURE) begin
          cap_hit[ke] = (cfg_reg[ke][`CCU_CF_EDGE_LO] & rise) | (cfg_reg[ke][`CCU_CF_EDGE_HI] & fall);
        end
      end
    end
    ev_set = cmp_hit | cap_hit;
  end

  // pin drive and next pin level; later statements win, so a mode 3
  // match in the overflow cycle leaves the pin set
  always @* begin
    pin_next = pin_reg;
    pin_oe   = {NPIN{1'b0}};
    mode_p   = 3'h0;
    ts_p     = 1'b0;
    for (kp = 0; kp < NPIN; kp = kp + 1) begin
      mode_p = cfg_reg[kp][`CCU_CF_MODE_HI:`CCU_CF_MODE_LO];
      ts_p   = cfg_reg[kp][`CCU_CF_TSEL];
      // capture and interrupt-only modes leave the pin to the outside
      pin_oe[kp] = (mode_p == `CCU_M_CMP1) || (mode_p == `CCU_M_CMP3);
      if (mode_p == `CCU_M_CMP1 && cmp_hit[kp]) begin
        pin_next[kp] = ~pin_next[kp];
      end
      if (mode_p == `CCU_M_CMP3 && ovf_d_reg[ts_p]) begin
        pin_next[kp] = 1'b0;
      end
      if (mode_p == `CCU_M_CMP3 && cmp_hit[kp]) begin
        pin_next[kp] = 1'b1;
      end
    end
    // the partner channel shares the low pin; a match on either flips it
    for (kp = 0; kp < 8; kp = kp + 1) begin
      if (double_reg[kp]) begin
        pin_oe[kp] = 1'b1;
        if (cmp_hit[kp+8] && cfg_reg[kp+8][`CCU_CF_MODE_HI]) begin
          pin_next[kp] = ~pin_next[kp];
        end
        // a mode 1 low channel has flipped the pin once already
        if (cmp_hit[kp] && cfg_reg[kp][`CCU_CF_MODE_HI:`CCU_CF_MODE_LO] != `CCU_M_CMP1) begin
          pin_next[kp] = ~pin_next[kp];
        end
      end
    end
  end

  // prescaler, timers, delayed tick and overflow
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_reg     <= {`CCU_PRE_W{1'b0}};
      ext_d_reg   <= 1'b0;
      tval_reg[0] <= 16'h0000;
      tval_reg[1] <= 16'h0000;
      trel_reg[0] <= 16'h0000;
      trel_reg[1] <= 16'h0000;
      tctrl_reg   <= `CCU_TCTRL_RST;
      adv_d_reg   <= 2'h0;
      ovf_d_reg   <= 2'h0;
    end else begin
      pre_reg   <= pre_reg + 1'b1;
      ext_d_reg <= ext_count_in;
      adv_d_reg <= tick;
      ovf_d_reg <= ovf;
      // a new run or source takes effect on the next tick decode
      if (wr_in && addr_in == `CCU_A_TCTRL) begin
        tctrl_reg <= wdata_in;
      end
      // a new reload value is used from the next overflow on
      if (wr_in && addr_in == `CCU_A_TREL0) begin
        trel_reg[0] <= wdata_in;
      end
      if (wr_in && addr_in == `CCU_A_TREL1) begin
        trel_reg[1] <= wdata_in;
      end
      for (kr = 0; kr < 2; kr = kr + 1) begin
        if (ovf[kr]) begin
          tval_reg[kr] <= trel_reg[kr];
        end else if (tick[kr]) begin
          tval_reg[kr] <= tval_reg[kr] + 1'b1;
        end
      end
      // a software write to the timer wins over counting
      if (wr_in && addr_in == `CCU_A_TVAL0) begin
        tval_reg[0] <= wdata_in;
      end
      if (wr_in && addr_in == `CCU_A_TVAL1) begin
        tval_reg[1] <= wdata_in;
      end
    end
  end

  // channel array, interrupt status and pins
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      istat_reg  <= {NCH{1'b0}};
      imask_reg  <= {NCH{1'b0}};
      double_reg <= 8'h00;
      done_reg   <= {NCH{1'b0}};
      pin_reg    <= {NPIN{1'b0}};
      pin_d_reg  <= {NPIN{1'b0}};
      for (kc = 0; kc < NCH; kc = kc + 1) begin
        cfg_reg[kc] <= `CCU_CFG_RST;
        val_reg[kc] <= 16'h0000;
      end
    end else begin
      pin_d_reg <= cc_pin_in;
      pin_reg   <= pin_next;
      // set wins over a write-one-to-clear in the same cycle
      // compare and capture interrupt
      istat_reg <= (istat_reg & ~((wr_in && addr_in == `CCU_A_ISTAT) ? wdata_in : 16'h0000)) | ev_set;
      if (wr_in && addr_in == `CCU_A_IMASK) begin
        imask_reg <= wdata_in;
      end
      if (wr_in && addr_in == `CCU_A_DOUBLE) begin
        double_reg <= wdata_in[7:0];
      end
      for (kc = 0; kc < NCH; kc = kc + 1) begin
        if (cmp_hit[kc] && (cfg_reg[kc][`CCU_CF_MODE_HI:`CCU_CF_MODE_LO] == `CCU_M_CMP2 ||
                            cfg_reg[kc][`CCU_CF_MODE_HI:`CCU_CF_MODE_LO] == `CCU_M_CMP3)) begin
          done_reg[kc] <= 1'b1;
        end else if (ovf_d_reg[cfg_reg[kc][`CCU_CF_TSEL]] && !cfg_reg[kc][`CCU_CF_SINGLE]) begin
          // a new timer period re-arms a channel not held by single event
          done_reg[kc] <= 1'b0;
        end
        if (cmp_hit[kc] && cfg_reg[kc][`CCU_CF_SINGLE]) begin
          done_reg[kc] <= 1'b1;
        end
        if (cap_hit[kc]) begin
          val_reg[kc] <= tval_reg[cfg_reg[kc][`CCU_CF_TSEL]];
        end
        // a software write wins over a capture in the same cycle
        if (wr_in && addr_in == (`CCU_A_VAL_BASE + kc)) begin
          val_reg[kc] <= wdata_in;
        end
        // rewriting the config re-arms the channel
        if (wr_in && addr_in == (`CCU_A_CFG_BASE + kc)) begin
          cfg_reg[kc]  <= wdata_in[6:0];
          done_reg[kc] <= 1'b0;
        end
      end
    end
  end

  // read decode; unmapped addresses read zero
  always @* begin
    rd_mux = 16'h0000;
    case (addr_in)
      `CCU_A_TCTRL:  rd_mux = tctrl_reg;
      `CCU_A_TVAL0:  rd_mux = tval_reg[0];
      `CCU_A_TREL0:  rd_mux = trel_reg[0];
      `CCU_A_TVAL1:  rd_mux = tval_reg[1];
      `CCU_A_TREL1:  rd_mux = trel_reg[1];
      `CCU_A_ISTAT:  rd_mux = istat_reg;
      `CCU_A_IMASK:  rd_mux = imask_reg;
      `CCU_A_PINS:   rd_mux = {6'h00, pin_reg};
      `CCU_A_DOUBLE: rd_mux = {8'h00, double_reg};
      default: begin
        if (addr_in[7:4] == 4'h1)
          rd_mux = {9'h000, cfg_reg[addr_in[3:0]]};
        else if (addr_in[7:4] == 4'h2)
          rd_mux = val_reg[addr_in[3:0]];
      end
    endcase
  end

  // read data stand exactly one cycle after the strobe; zero between
  // answers, so a stale value can never be mistaken for a new one
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 16'h0000;
    end else if (rd_in) begin
      rdata_out <= rd_mux;
    end else begin
      rdata_out <= 16'h0000;
    end
  end

endmodule

// *** verilog/ccu_map.vh ***
`ifndef CCU_MAP_VH
`define CCU_MAP_VH
// register addresses (word addresses on the plain port)
`define CCU_A_TCTRL     8'h00
`define CCU_A_TVAL0     8'h01
`define CCU_A_TREL0     8'h02
`define CCU_A_TVAL1     8'h03
`define CCU_A_TREL1     8'h04
`define CCU_A_ISTAT     8'h05
`define CCU_A_IMASK     8'h06
`define CCU_A_PINS      8'h07
`define CCU_A_DOUBLE    8'h08
`define CCU_A_CFG_BASE  8'h10
`define CCU_A_VAL_BASE  8'h20
// timer control fields: timer k uses bits [8k+3:8k]
`define CCU_TC_RUN      0
`define CCU_TC_SEL_LO   1
`define CCU_TC_SEL_HI   3
`define CCU_TC_STRIDE   8
`define CCU_TC_STAGGER  15
`define CCU_TCTRL_RST   16'h0000
// count clock sources
`define CCU_SEL_DIV1    3'h0
`define CCU_SEL_DIV8    3'h1
`define CCU_SEL_DIV64   3'h2
`define CCU_SEL_DIV512  3'h3
`define CCU_SEL_GPT6    3'h6
`define CCU_SEL_EXT     3'h7
`define CCU_PRE_W       9
`define CCU_STAGGER_DIV 3'h7
// channel config fields
`define CCU_CF_MODE_HI  2
`define CCU_CF_MODE_LO  0
`define CCU_CF_TSEL     3
`define CCU_CF_EDGE_HI  5
`define CCU_CF_EDGE_LO  4
`define CCU_CF_SINGLE   6
`define CCU_CFG_RST     7'h00
// channel modes
`define CCU_M_OFF       3'h0
`define CCU_M_CAPTURE   3'h1
`define CCU_M_CMP0      3'h4
`define CCU_M_CMP1      3'h5
`define CCU_M_CMP2      3'h6
`define CCU_M_CMP3      3'h7
// capture edges
`define CCU_E_RISE      2'h1
`define CCU_E_FALL      2'h2
`define CCU_E_BOTH      2'h3
`define CCU_TMAX        16'hFFFF
`endif

// *** tb/ccu_cc_properties.sv ***
`timescale 1ns/1ns
`include "ccu_map.vh"
module ccu_cc_properties #(parameter NPIN = 10) (
  input wire            core_clk_in,
  input wire            rst_in,
  input wire [7:0]      addr_in,
  input wire [15:0]     wdata_in,
  input wire            wr_in,
  input wire            rd_in,
  input wire [15:0]     rdata_out,
  input wire [NPIN-1:0] cc_pin_out,
  input wire [NPIN-1:0] cc_pin_oe_out,
  input wire            irq_out
);
  reg [15:0] tctrl_reg;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // shadow of the timer control word, so its read-back can be judged
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in)
      tctrl_reg <= `CCU_TCTRL_RST;
    else if (wr_in && addr_in == `CCU_A_TCTRL)
      tctrl_reg <= wdata_in;
  end
  rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data not zero outside a read answer");
  unmapped_zero_a: assert property ($past(rd_in) && $past(addr_in) inside {[8'h09:8'h0F]} |-> rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  tctrl_back_a: assert property ($past(rd_in) && $past(addr_in) == `CCU_A_TCTRL |-> rdata_out == tctrl_reg)
    else $error("timer control read-back wrong");
  reset_quiet_a: assert property (disable iff (1'b0) rst_in |-> !irq_out && cc_pin_out == 0 && cc_pin_oe_out == 0)
    else $error("outputs active during reset");
  oe_after_write_a: assert property ($changed(cc_pin_oe_out) |-> $past(wr_in))
    else $error("pin direction changed without a write");
  pin_hold_a: assert property (((cc_pin_out ^ $past(cc_pin_out)) & ~cc_pin_oe_out & ~$past(cc_pin_oe_out)) == 0)
    else $error("undriven pin level changed");
  irq_fall_a: assert property ($fell(irq_out) |-> $past(wr_in))
    else $error("interrupt dropped without a write");
  irq_mask_a: assert property ($past(wr_in) && $past(addr_in) == `CCU_A_IMASK && $past(wdata_in) == 16'h0000 |-> !irq_out)
    else $error("interrupt high with all sources masked");
endmodule
bind ccu_capture_compare ccu_cc_properties #(.NPIN(NPIN)) ccu_cc_properties_inst (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .cc_pin_out(cc_pin_out), .cc_pin_oe_out(cc_pin_oe_out), .irq_out(irq_out));

// *** tb/ccu_pin_model.sv ***
`timescale 1ns/1ns
module ccu_pin_model #(parameter NPIN = 10) (
  input  wire            core_clk_in,
  input  wire [NPIN-1:0] level_in,
  input  wire [NPIN-1:0] cc_pin_out,
  input  wire [NPIN-1:0] cc_pin_oe_out,
  output wire [NPIN-1:0] cc_pin_in
);
  reg [NPIN-1:0] drive_reg = {NPIN{1'b0}};
  // edge launch
  // edges leave just after a clock edge and are then held
  always @(posedge core_clk_in) begin
    drive_reg <= level_in;
  end
  // pin direction
  // a pin the block drives shows its level, never ours
  assign cc_pin_in = (cc_pin_oe_out & cc_pin_out) | (~cc_pin_oe_out & drive_reg);
endmodule

// *** tb/tb_dual_timebase_capture_compare.sv ***
`timescale 1ns/1ns
`include "ccu_map.vh"
module tb_dual_timebase_capture_compare;
  reg         core_clk_in = 1'b0;
  reg         rst_in = 1'b0;
  reg  [7:0]  addr_in = 8'h00;
  reg  [15:0] wdata_in = 16'h0000;
  reg         wr_in = 1'b0;
  reg         rd_in = 1'b0;
  reg         gp_ovf = 1'b0;
  reg         ext_cnt = 1'b0;
  reg  [9:0]  level = 10'h000;
  wire [15:0] rdata_out;
  wire [9:0]  pin_in;
  wire [9:0]  pin_out;
  wire [9:0]  pin_oe;
  wire        irq_out;
  integer     fail_count = 0;
  integer     checks = 0;
  integer     cyc = 0;
  integer     i;
  ccu_capture_compare ccu_capture_compare_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .gp_sixth_timer_ovf_in(gp_ovf),
    .ext_count_in(ext_cnt), .cc_pin_in(pin_in), .cc_pin_out(pin_out), .cc_pin_oe_out(pin_oe), .irq_out(irq_out));
  ccu_pin_model ccu_pin_model_inst (.core_clk_in(core_clk_in), .level_in(level), .cc_pin_out(pin_out),
    .cc_pin_oe_out(pin_oe), .cc_pin_in(pin_in));
  always #2 core_clk_in = ~core_clk_in;
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      results;
    end
  end
  task results;
    begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task cmp(input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge core_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rdc(input [7:0] a, input [15:0] exp);
    begin
      @(posedge core_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
      #1 cmp(rdata_out, exp);
    end
  endtask
  task wpin(input integer b, input v);
    integer n;
    begin
      n = 0;
      while (pin_out[b] !== v && n < 60) begin
        @(posedge core_clk_in);
        n = n + 1;
      end
      cmp({15'h0000, pin_out[b]}, {15'h0000, v});
    end
  endtask
  task t_regs;
    begin
      rdc(`CCU_A_TCTRL, `CCU_TCTRL_RST);
      rdc(`CCU_A_CFG_BASE + 8'h05, {9'h000, `CCU_CFG_RST});
      wr(`CCU_A_TREL1, 16'hA5C3);
      rdc(`CCU_A_TREL1, 16'hA5C3);
      rdc(8'h0C, 16'h0000);
      $display("register test done");
    end
  endtask
  // timer 1 on sixth-timer pulses wraps through its reload, timer 0 on external edges
  task t_sources;
    begin
      wr(`CCU_A_TVAL0, 16'h0100);
      wr(`CCU_A_TVAL1, 16'hFFFE);
      wr(`CCU_A_TREL1, 16'h1000);
      wr(`CCU_A_TCTRL, 16'h0D0F);
      for (i = 0; i < 3; i = i + 1) begin
        @(posedge core_clk_in);
        gp_ovf <= 1'b1;
        ext_cnt <= ~ext_cnt;
        @(posedge core_clk_in);
        gp_ovf <= 1'b0;
      end
      repeat (4) @(posedge core_clk_in);
      wr(`CCU_A_TCTRL, 16'h0000);
      rdc(`CCU_A_TVAL1, 16'h1001);
      rdc(`CCU_A_TVAL0, 16'h0102);
      $display("timer source test done");
    end
  endtask
  // timer 0 runs for exactly 64 edges, then its count is read
  task t_rate(input [15:0] ctrl, input [15:0] exp);
    begin
      wr(`CCU_A_TVAL0, 16'h0000);
      wr(`CCU_A_TCTRL, ctrl);
      repeat (62) @(posedge core_clk_in);
      wr(`CCU_A_TCTRL, 16'h0000);
      rdc(`CCU_A_TVAL0, exp);
      $display("rate test done");
    end
  endtask
  task edge_cap(input lvl, input hit, input [15:0] tv);
    begin
      wr(`CCU_A_VAL_BASE + 8'h01, 16'h0000);
      wr(`CCU_A_ISTAT, 16'hFFFF);
      level[1] <= lvl;
      repeat (6) @(posedge core_clk_in);
      rdc(`CCU_A_VAL_BASE + 8'h01, hit ? tv : 16'h0000);
      rdc(`CCU_A_ISTAT, {14'h0000, hit, 1'b0});
      cmp({15'h0000, irq_out}, {15'h0000, hit});
    end
  endtask
  // every edge choice, the last one on the second timer
  task t_capture;
    reg [1:0] e;
    begin
      wr(`CCU_A_IMASK, 16'h0002);
      for (i = 1; i < 4; i = i + 1) begin
        e = i;
        wr(`CCU_A_TVAL0, {14'h0800, e});
        wr(`CCU_A_TVAL1, 16'h3AB3);
        wr(`CCU_A_CFG_BASE + 8'h01, {9'h000, 1'b0, e, e == 2'h3, `CCU_M_CAPTURE});
        edge_cap(1'b1, e[0], (e == 2'h3) ? 16'h3AB3 : {14'h0800, e});
        edge_cap(1'b0, e[1], (e == 2'h3) ? 16'h3AB3 : {14'h0800, e});
      end
      $display("capture test done");
    end
  endtask
  task t_compare;
    begin
      wr(`CCU_A_TREL0, 16'hFFF0);
      wr(`CCU_A_TVAL0, 16'hFFF0);
      wr(`CCU_A_IMASK, 16'h0001);
      wr(`CCU_A_ISTAT, 16'hFFFF);
      for (i = 0; i < 4; i = i + 1)
        wr(`CCU_A_VAL_BASE + i[7:0], 16'hFFF6);
      wr(`CCU_A_CFG_BASE, {13'h0000, `CCU_M_CMP1});
      wr(`CCU_A_CFG_BASE + 8'h02, {13'h0000, `CCU_M_CMP2});
      wr(`CCU_A_CFG_BASE + 8'h03, {13'h0000, `CCU_M_CMP0});
      wr(`CCU_A_TCTRL, 16'h0001);
      wpin(0, 1'b1);
      wpin(0, 1'b0);
      wr(`CCU_A_TCTRL, 16'h0000);
      rdc(`CCU_A_ISTAT, 16'h000D);
      cmp({14'h0000, pin_oe[3:2]}, 16'h0000);
      wr(`CCU_A_ISTAT, 16'h0001);
      rdc(`CCU_A_ISTAT, 16'h000C);
      cmp({15'h0000, irq_out}, 16'h0000);
      wr(`CCU_A_CFG_BASE, {13'h0000, `CCU_M_CMP3});
      wr(`CCU_A_TCTRL, 16'h0001);
      wpin(0, 1'b1);
      wpin(0, 1'b0);
      wr(`CCU_A_CFG_BASE, 16'h0045);
      wpin(0, 1'b1);
      repeat (40) @(posedge core_clk_in);
      cmp({15'h0000, pin_out[0]}, 16'h0001);
      wr(`CCU_A_DOUBLE, 16'h0001);
      wr(`CCU_A_VAL_BASE + 8'h08, 16'hFFF2);
      wr(`CCU_A_CFG_BASE + 8'h08, {13'h0000, `CCU_M_CMP1});
      wr(`CCU_A_CFG_BASE, 16'h0000);
      wpin(0, 1'b0);
      wpin(0, 1'b1);
      wr(`CCU_A_TCTRL, 16'h0000);
      wr(`CCU_A_IMASK, 16'h0000);
      $display("compare test done");
    end
  endtask
  initial begin
    rst_in <= 1'b1;
    repeat (12) @(posedge core_clk_in);
    rst_in <= 1'b0;
    t_regs;
    t_sources;
    t_rate(16'h8001, 16'h0008);
    t_rate(16'h0001, 16'h0040);
    t_rate(16'h0005, 16'h0001);
    t_capture;
    t_compare;
    results;
  end
endmodule
